// File: hw/interp_pkg.sv
// constants for the four-axis interpolation controller
package interp_pkg;
   // ******************************
   // register map (addr[2:0], axis in addr[4:3])
   // ******************************
   localparam logic [2:0] REG_MODE          = 3'h0;
   localparam logic [2:0] REG_ENDPOINT      = 3'h1;
   localparam logic [2:0] REG_MASTER_AMOUNT = 3'h2;
   localparam logic [2:0] REG_SPEED         = 3'h3;
   localparam logic [2:0] REG_COMMAND       = 3'h4;
   localparam logic [2:0] REG_STATUS        = 3'h5;
   localparam logic [2:0] REG_SPEED_MON     = 3'h6;
   localparam logic [2:0] REG_INTERP_STATUS = 3'h7;
   // ******************************
   // mode register fields and codes
   // ******************************
   localparam int         CONST_SPEED_BIT   = 15;
   localparam logic [6:0] MODE_LIN1_CONT    = 7'h60;
   localparam logic [6:0] MODE_LIN1         = 7'h61;
   localparam logic [6:0] MODE_LIN2_CONT    = 7'h62;
   localparam logic [6:0] MODE_LIN2         = 7'h63;
   localparam logic [6:0] MODE_CIRC_FIRST   = 7'h64;
   localparam logic [6:0] MODE_CIRC_LAST    = 7'h67;
   // ******************************
   // command register fields
   // ******************************
   localparam logic [7:0] CMD_START         = 8'h01;
   localparam logic [7:0] CMD_STOP          = 8'h02;
   localparam int         CMD_SEL_LSB       = 8;
   // ******************************
   // status register bits
   // ******************************
   localparam int         STAT_RUN          = 0;
   localparam int         STAT_END          = 1;
   localparam int         STAT_ERR          = 2;
   localparam int         STAT_DATA_ERR     = 3;
   // ******************************
   // interval scaling, fixed point with 7 fraction bits
   // ******************************
   localparam logic [7:0] SCALE_ROOT2       = 8'hb5;
   localparam logic [7:0] SCALE_ROOT3       = 8'hde;
   localparam int         SCALE_SHIFT       = 7;
   localparam logic [15:0] SPEED_RST        = 16'h0000;
endpackage

// File: hw/interp_ctrl.sv
// four-axis linear interpolation controller with register port and step outputs
//
// Summary of operation
// [RQ1] linear 1 speed comes from the first grouped axis in X, Y, Z, U order
// [RQ2] circular group keeps its own control axis apart from the linear 1 group
// [RQ3] each linear 2 axis runs its own timer and accumulator
// [RQ4] interval scaling acts in linear 1 only, never in linear 2
// [RQ5] bit 15 of each mode register enables that axis in scaling
// [RQ6] two flagged simultaneous pulses stretch next interval by root two, three by root three
// [RQ7] one flagged axis pulsing with unflagged ones leaves the interval unchanged
// [RQ8] four flagged axes pulsing together scale by root three at most
// [RQ9] scaled intervals keep the combined speed at the programmed speed for two or three flagged axes, not for four
// [RQ10] all grouped axes show identical running, end and error flags
// [RQ11] speed monitor is valid on control axes only, master speed in linear 2
// [RQ12] host keeps constant speed, equal ramps, no S-curve speed changes
// [RQ13] mode 60h runs linear 1 until a stop command
// [RQ14] continuous linear 1 with all endpoints zero pulses all axes equally
// [RQ15] mode 61h needs two to four axes, one axis stops with data error
// [RQ16] travel direction follows the endpoint sign
// [RQ17] largest magnitude axis is master and pulses every step
// [RQ18] host starts with select bits for all grouped axes, through any axis
// [RQ19] path stays within half a step of the ideal line
// [RQ20] mode 62h pulses per ratio of endpoint to master amount until stopped
// [RQ21] linear 2 start with zero master amount raises data error
// [RQ22] slaves accumulate their magnitude per master step, pulse on overflow
`timescale 1ns/1ps
module interp_ctrl (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // motor driver outputs
   output logic      [3:0]  step_out,
   output logic      [3:0]  dir_out
);
   typedef enum logic {G_IDLE, G_RUN} grp_st_t;

   typedef struct packed {
      logic [3:0][15:0] mode;
      logic [3:0][15:0] ep;
      logic [3:0][15:0] mamt;
      logic [3:0][15:0] spd;
      logic [3:0]       run;
      logic [3:0]       fin;
      logic [3:0]       err;
      logic [3:0]       dir;
      logic [3:0]       step;
      logic [3:0]       lin2;
      logic [3:0][16:0] acc;
      logic [3:0][15:0] a_tmr;
      logic [3:0][15:0] a_cnt;
      grp_st_t          gs;
      logic [3:0]       g_mask;
      logic [1:0]       g_master;
      logic [1:0]       g_ctrl;
      logic             g_cont;
      logic             g_zero;
      logic [23:0]      g_tmr;
      logic [23:0]      g_ivl;
      logic [15:0]      g_cnt;
      logic [1:0]       c_ctrl;
      logic             c_valid;
      logic [31:0]      rdata;
   } state_t;

   state_t q;
   state_t d;

   // ******************************
   // helpers
   // ******************************
   function automatic logic [15:0] mag(input logic [15:0] v);
      mag = v[15] ? 16'(-v) : v;
   endfunction

   function automatic logic [2:0] popcount(input logic [3:0] v);
      popcount = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
   endfunction

   function automatic logic [1:0] first_axis(input logic [3:0] m);
      first_axis = 2'h0;
      for (int i = 3; i >= 0; i--) begin
         if (m[i]) begin
            first_axis = 2'(i);
         end
      end
   endfunction

   function automatic logic [1:0] pick_master(input logic [3:0] m, input logic [3:0][15:0] e);
      logic [15:0] best;
      best = 16'h0000;
      pick_master = first_axis(m);
      for (int i = 0; i < 4; i++) begin
         if (m[i] && mag(e[i]) > best) begin
            best        = mag(e[i]);
            pick_master = 2'(i);
         end
      end
   endfunction

   function automatic logic [23:0] scale_ivl(input logic [15:0] s, input logic [2:0] n);
      logic [31:0] base;
      logic [31:0] prod;
      base = {16'h0000, (s == 16'h0000) ? 16'h0001 : s};
      prod = base;
      if (n == 3'h2) begin
         prod = base * {24'h000000, interp_pkg::SCALE_ROOT2};
      end else if (n >= 3'h3) begin
         prod = base * {24'h000000, interp_pkg::SCALE_ROOT3};
      end
      scale_ivl = (n >= 3'h2) ? prod[interp_pkg::SCALE_SHIFT +: 24] : base[23:0];
   endfunction

   function automatic logic is_lin1(input logic [15:0] m);
      is_lin1 = (m[6:0] == interp_pkg::MODE_LIN1_CONT) || (m[6:0] == interp_pkg::MODE_LIN1);
   endfunction

   function automatic logic is_lin2(input logic [15:0] m);
      is_lin2 = (m[6:0] == interp_pkg::MODE_LIN2_CONT) || (m[6:0] == interp_pkg::MODE_LIN2);
   endfunction

   // ******************************
   // decode
   // ******************************
   logic [1:0]       axis;
   logic [3:0]       sel;
   logic             cmd_wr;
   logic             start_wr;
   logic             stop_wr;
   logic [3:0]       flags;
   logic [3:0]       lin1_sel;
   logic [3:0]       lin2_sel;
   logic [3:0]       circ_sel;
   logic [3:0][15:0] mags;
   logic [15:0]      mag_m;
   logic             g_fire;
   logic [3:0]       g_pulse;
   logic [3:0][16:0] sum;
   logic [1:0]       new_master;

   always_comb begin
      axis     = reg_addr[4:3];
      sel      = reg_wdata[interp_pkg::CMD_SEL_LSB +: 4];
      cmd_wr   = reg_wr && (reg_addr[2:0] == interp_pkg::REG_COMMAND);
      start_wr = cmd_wr && (reg_wdata[7:0] == interp_pkg::CMD_START);
      stop_wr  = cmd_wr && (reg_wdata[7:0] == interp_pkg::CMD_STOP);
      for (int i = 0; i < 4; i++) begin
         flags[i]    = q.mode[i][interp_pkg::CONST_SPEED_BIT]; // RQ5
         mags[i]     = mag(q.ep[i]);
         lin1_sel[i] = sel[i] && is_lin1(q.mode[i]) && !q.run[i];
         lin2_sel[i] = sel[i] && is_lin2(q.mode[i]) && !q.run[i];
         circ_sel[i] = sel[i] && (q.mode[i][6:0] >= interp_pkg::MODE_CIRC_FIRST)
                       && (q.mode[i][6:0] <= interp_pkg::MODE_CIRC_LAST);
      end
      mag_m      = mags[q.g_master];
      new_master = pick_master(lin1_sel, q.ep); // RQ17
   end

   // ******************************
   // next state
   // ******************************
   always_comb begin
      d       = q;
      d.step  = 4'h0;
      d.rdata = 32'h0000_0000;
      g_fire  = 1'b0;
      g_pulse = 4'h0;
      sum     = '0;
      if (reg_wr) begin
         unique case (reg_addr[2:0])
            interp_pkg::REG_MODE:          d.mode[axis] = reg_wdata[15:0];
            interp_pkg::REG_ENDPOINT:      d.ep[axis]   = reg_wdata[15:0];
            interp_pkg::REG_MASTER_AMOUNT: d.mamt[axis] = reg_wdata[15:0];
            interp_pkg::REG_SPEED:         d.spd[axis]  = reg_wdata[15:0];
            default: ;
         endcase
      end
      // linear 1 group engine
      if (q.gs == G_RUN) begin
         if (q.g_tmr == 24'h000000) begin
            g_fire = 1'b1;
            for (int i = 0; i < 4; i++) begin
               if (q.g_mask[i]) begin
                  if (2'(i) == q.g_master || q.g_zero) begin
                     g_pulse[i] = 1'b1; // RQ17 RQ14
                  end else begin
                     sum[i] = q.acc[i] + {1'b0, mags[i]}; // RQ22 RQ19
                     if (sum[i] >= {1'b0, mag_m}) begin
                        g_pulse[i] = 1'b1;
                        d.acc[i]   = sum[i] - {1'b0, mag_m};
                     end else begin
                        d.acc[i]   = sum[i];
                     end
                  end
               end
            end
            d.step  = g_pulse;
            d.g_ivl = scale_ivl(q.spd[q.g_ctrl], popcount(g_pulse & flags)); // RQ1 RQ6 RQ7 RQ8 RQ9
            d.g_tmr = d.g_ivl - 24'h000001;
            d.g_cnt = q.g_cnt + 16'h0001;
            if (!q.g_cont && d.g_cnt == mag_m) begin
               d.gs  = G_IDLE; // RQ13
               d.run = q.run & ~q.g_mask; // RQ10
               d.fin = q.fin | q.g_mask;
            end
         end else begin
            d.g_tmr = q.g_tmr - 24'h000001;
         end
      end
      // linear 2 axes, each on its own timer
      for (int i = 0; i < 4; i++) begin
         if (q.run[i] && q.lin2[i]) begin
            if (q.a_tmr[i] == 16'h0000) begin
               sum[i] = q.acc[i] + {1'b0, mags[i]}; // RQ3 RQ22
               if (sum[i] >= {1'b0, mag(q.mamt[i])}) begin
                  d.step[i] = 1'b1; // RQ20
                  d.acc[i]  = sum[i] - {1'b0, mag(q.mamt[i])};
               end else begin
                  d.acc[i]  = sum[i];
               end
               d.a_tmr[i] = (q.spd[i] == 16'h0000) ? 16'h0000 : q.spd[i] - 16'h0001; // RQ4
               d.a_cnt[i] = q.a_cnt[i] + 16'h0001;
               if (q.mode[i][6:0] == interp_pkg::MODE_LIN2 && d.a_cnt[i] == mag(q.mamt[i])) begin
                  d.run[i] = 1'b0;
                  d.fin[i] = 1'b1;
               end
            end else begin
               d.a_tmr[i] = q.a_tmr[i] - 16'h0001;
            end
         end
      end
      // stop: any grouped axis stops the whole group
      if (stop_wr) begin
         d.fin = d.fin | (q.run & sel);
         d.run = d.run & ~sel;
         if (q.gs == G_RUN && |(sel & q.g_mask)) begin
            d.gs  = G_IDLE; // RQ10
            d.run = d.run & ~q.g_mask;
            d.fin = d.fin | q.g_mask;
         end
      end
      // start: the four select bits name every axis to move
      if (start_wr) begin
         if (|lin1_sel && q.gs == G_IDLE) begin // RQ18
            d.fin = d.fin & ~lin1_sel;
            d.err = d.err & ~lin1_sel;
            if (popcount(lin1_sel) < 3'h2) begin
               d.err = d.err | lin1_sel; // RQ15
            end else if (!is_lin1(q.mode[first_axis(lin1_sel)]) ||
                         (q.mode[first_axis(lin1_sel)][6:0] == interp_pkg::MODE_LIN1 &&
                          mags[new_master] == 16'h0000)) begin
               d.fin = d.fin | lin1_sel;
            end else begin
               d.gs       = G_RUN;
               d.g_mask   = lin1_sel;
               d.g_ctrl   = first_axis(lin1_sel); // RQ1
               d.g_master = new_master;
               d.g_cont   = q.mode[first_axis(lin1_sel)][6:0] == interp_pkg::MODE_LIN1_CONT; // RQ13
               d.g_zero   = mags[new_master] == 16'h0000; // RQ14
               d.g_tmr    = 24'h000000;
               d.g_ivl    = scale_ivl(q.spd[first_axis(lin1_sel)], 3'h0);
               d.g_cnt    = 16'h0000;
               d.run      = d.run | lin1_sel;
               for (int i = 0; i < 4; i++) begin
                  if (lin1_sel[i]) begin
                     d.dir[i]  = q.ep[i][15]; // RQ16
                     d.lin2[i] = 1'b0;
                     d.acc[i]  = {2'b00, mags[new_master][15:1]}; // RQ19
                  end
               end
            end
         end
         for (int i = 0; i < 4; i++) begin
            if (lin2_sel[i]) begin
               d.fin[i] = 1'b0;
               d.err[i] = 1'b0;
               if (q.mamt[i] == 16'h0000) begin
                  d.err[i] = 1'b1; // RQ21
               end else begin
                  d.run[i]   = 1'b1;
                  d.lin2[i]  = 1'b1;
                  d.dir[i]   = q.ep[i][15]; // RQ16
                  d.acc[i]   = {1'b0, mag(q.mamt[i]) >> 1};
                  d.a_tmr[i] = 16'h0000;
                  d.a_cnt[i] = 16'h0000;
               end
            end
         end
         if (|circ_sel) begin
            d.c_ctrl  = first_axis(circ_sel); // RQ2
            d.c_valid = 1'b1;
         end
      end
      // reads answer in the next cycle
      if (reg_rd) begin
         unique case (reg_addr[2:0])
            interp_pkg::REG_MODE:          d.rdata = {16'h0000, q.mode[axis]};
            interp_pkg::REG_ENDPOINT:      d.rdata = {{16{q.ep[axis][15]}}, q.ep[axis]};
            interp_pkg::REG_MASTER_AMOUNT: d.rdata = {{16{q.mamt[axis][15]}}, q.mamt[axis]};
            interp_pkg::REG_SPEED:         d.rdata = {16'h0000, q.spd[axis]};
            interp_pkg::REG_STATUS: begin
               d.rdata[interp_pkg::STAT_RUN]      = q.run[axis];
               d.rdata[interp_pkg::STAT_END]      = q.fin[axis];
               d.rdata[interp_pkg::STAT_ERR]      = q.err[axis];
               d.rdata[interp_pkg::STAT_DATA_ERR] = q.err[axis];
            end
            interp_pkg::REG_SPEED_MON: begin
               if (q.run[axis] && q.lin2[axis]) begin
                  d.rdata = {16'h0000, q.spd[axis]}; // RQ11
               end else if (q.gs == G_RUN && axis == q.g_ctrl) begin
                  d.rdata = {8'h00, q.g_ivl}; // RQ11
               end
            end
            interp_pkg::REG_INTERP_STATUS: begin
               d.rdata = {20'h00000, q.c_valid, q.c_ctrl, q.gs == G_RUN, q.g_ctrl, q.g_master, q.g_mask};
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign step_out  = q.step;
   assign dir_out   = q.dir;

   // ******************************
   // assertions
   // ******************************
   property p_ctrl_first;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.gs == G_RUN) |-> (q.g_ctrl == first_axis(q.g_mask) && popcount(q.g_mask) >= 3'h2);
   endproperty
   a_ctrl_first: assert property (p_ctrl_first) else $error("control axis not first grouped axis"); // RQ1

   property p_flags_same;
      @(posedge sys_clk) disable iff (!rst_n)
      (q.gs == G_RUN) |-> ((q.run & q.g_mask) == q.g_mask) && ((q.err & q.g_mask) == 4'h0);
   endproperty
   a_flags_same: assert property (p_flags_same) else $error("grouped axes flags differ"); // RQ10

   property p_master_step;
      @(posedge sys_clk) disable iff (!rst_n)
      g_fire |=> step_out[q.g_master];
   endproperty
   a_master_step: assert property (p_master_step) else $error("master missed a step"); // RQ17

   property p_single_err;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_wr && q.gs == G_IDLE && popcount(lin1_sel) == 3'h1) |=> ((q.err & q.run) == 4'h0) && (q.err != 4'h0);
   endproperty
   a_single_err: assert property (p_single_err) else $error("single axis start without error"); // RQ15

   property p_lin2_zero;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_wr && lin2_sel[0] && q.mamt[0] == 16'h0000) |=> (q.err[0] && !q.run[0]) [*2];
   endproperty
   a_lin2_zero: assert property (p_lin2_zero) else $error("zero master amount not refused"); // RQ21

   property p_scale_two;
      @(posedge sys_clk) disable iff (!rst_n)
      (g_fire && popcount(g_pulse & flags) == 3'h2) |=> (q.g_ivl == scale_ivl($past(q.spd[q.g_ctrl]), 3'h2));
   endproperty
   a_scale_two: assert property (p_scale_two) else $error("two-axis interval not scaled"); // RQ6

   property p_no_scale;
      @(posedge sys_clk) disable iff (!rst_n)
      (g_fire && popcount(g_pulse & flags) < 3'h2 && q.spd[q.g_ctrl] != 16'h0000) |=>
         (q.g_ivl == {8'h00, $past(q.spd[q.g_ctrl])});
   endproperty
   a_no_scale: assert property (p_no_scale) else $error("interval changed with one flagged axis"); // RQ7

   property p_scale_max;
      @(posedge sys_clk) disable iff (!rst_n)
      (g_fire && (g_pulse & flags) == 4'hf) |=> (q.g_ivl == scale_ivl($past(q.spd[q.g_ctrl]), 3'h3));
   endproperty
   a_scale_max: assert property (p_scale_max) else $error("four-axis interval not root three"); // RQ8

   property p_dir_sign;
      @(posedge sys_clk) disable iff (!rst_n)
      (start_wr && q.gs == G_IDLE && popcount(lin1_sel) >= 3'h2 && q.ep[first_axis(lin1_sel)][15]
       && mags[new_master] != 16'h0000) |=> dir_out[$past(first_axis(lin1_sel))];
   endproperty
   a_dir_sign: assert property (p_dir_sign) else $error("direction does not follow sign"); // RQ16

   property p_mon_idle;
      @(posedge sys_clk) disable iff (!rst_n)
      (reg_rd && reg_addr[2:0] == interp_pkg::REG_SPEED_MON && !q.run[axis]) |=> (reg_rdata == 32'h0000_0000);
   endproperty
   a_mon_idle: assert property (p_mon_idle) else $error("speed monitor valid on idle axis"); // RQ11

   c_three_axes: cover property (@(posedge sys_clk) disable iff (!rst_n) q.gs == G_RUN && popcount(q.g_mask) == 3'h3);
   c_lin2_run:   cover property (@(posedge sys_clk) disable iff (!rst_n) q.run[1] && q.lin2[1] && step_out[1]);
   c_zero_cont:  cover property (@(posedge sys_clk) disable iff (!rst_n) g_fire && q.g_zero);
   c_done:       cover property (@(posedge sys_clk) disable iff (!rst_n) q.gs == G_RUN ##1 q.gs == G_IDLE);
endmodule

// File: sim/step_driver_model.sv
// motor driver model: counts steps per axis and times the gap between steps
`timescale 1ns/1ps
module step_driver_model (
   // clock
   input wire logic       sys_clk,
   // step and direction from the controller
   input wire logic [3:0] step_out,
   input wire logic [3:0] dir_out
);
   int cyc     = 0;
   int pos[4]  = '{default: 0};
   int gap[4]  = '{default: 0};
   int last[4] = '{default: 0};

   // ************************
   // step counting
   // ************************
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 4; i++) begin
         if (step_out[i] === 1'b1) begin
            gap[i]  <= cyc - last[i];
            last[i] <= cyc;
            // direction line is read at the step
            pos[i]  <= (dir_out[i] === 1'b1) ? pos[i] - 1 : pos[i] + 1;
         end
      end
   end
endmodule

// File: sim/multi_axis_interpolation_control_test.sv
// self-checking bench for the four-axis interpolation controller
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module multi_axis_interpolation_control_test;
   logic        sys_clk   = 1'b0;
   logic        rst_n     = 1'b0;
   logic [4:0]  reg_addr  = 5'h00;
   logic [31:0] reg_wdata = 32'h00000000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [31:0] reg_rdata;
   logic [3:0]  step_out;
   logic [3:0]  dir_out;
   logic [31:0] d;
   int          n_mismatch = 0;
   int          num_checks = 0;
   int          p0[4];
   int          ctrl;
   int          hi;
   logic [3:0]  grp[5]     = '{4'h3, 4'h7, 4'hf, 4'h3, 4'he};
   logic [3:0]  flg[5]     = '{4'h3, 4'h7, 4'hf, 4'h1, 4'h6};
   int          exp_gap[5] = '{181, 222, 222, 128, 181};

   always #2 sys_clk = ~sys_clk;

   interp_ctrl uut (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .step_out  (step_out),
      .dir_out   (dir_out)
   );

   step_driver_model drv (
      .sys_clk  (sys_clk),
      .step_out (step_out),
      .dir_out  (dir_out)
   );

   // ************************
   // register port tasks
   // ************************
   task automatic wr(input logic [1:0] ax, input logic [2:0] r, input logic [31:0] v);
      @(posedge sys_clk);
      reg_addr  <= {ax, r};
      reg_wdata <= v;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [1:0] ax, input logic [2:0] r);
      @(posedge sys_clk);
      reg_addr <= {ax, r};
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic wait_end(input logic [1:0] ax);
      int i;
      for (i = 0; i < 3000; i++) begin
         rd(ax, interp_pkg::REG_STATUS);
         if (d[interp_pkg::STAT_END] === 1'b1) break;
      end
      if (i == 3000) begin
         n_mismatch++;
         $display("MISMATCH t=%0t move never ended", $time);
         report_and_stop();
      end
   endtask

   // ************************
   // main sequence
   // ************************
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      // status is read only, idle monitor reads zero
      wr(2'd0, interp_pkg::REG_STATUS, 32'h0000ffff);
      rd(2'd0, interp_pkg::REG_STATUS);
      `CHK(d, 32'h00000000)
      rd(2'd0, interp_pkg::REG_SPEED_MON);
      `CHK(d, 32'h00000000)
      // three-axis linear move, negative x
      wr(2'd0, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd1, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd2, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd0, interp_pkg::REG_ENDPOINT, 32'hfffffffb);
      wr(2'd1, interp_pkg::REG_ENDPOINT, 32'h0000000a);
      wr(2'd2, interp_pkg::REG_ENDPOINT, 32'h00000002);
      wr(2'd0, interp_pkg::REG_SPEED, 32'h00000006);
      wr(2'd2, interp_pkg::REG_COMMAND, 32'h00000701);
      rd(2'd0, interp_pkg::REG_INTERP_STATUS);
      `CHK(d[8:0], 9'h117)
      rd(2'd0, interp_pkg::REG_SPEED_MON);
      `CHK(d, 32'h00000006)
      rd(2'd1, interp_pkg::REG_SPEED_MON);
      `CHK(d, 32'h00000000)
      wait_end(2'd0);
      for (int i = 0; i < 3; i++) begin
         rd(2'(i), interp_pkg::REG_STATUS);
         `CHK(d, 32'h00000002)
      end
      `CHK(drv.pos[0], -5)
      `CHK(drv.pos[1], 10)
      `CHK(drv.pos[2], 2)
      `CHK(dir_out[0], 1'b1)
      `CHK(drv.gap[1], 6)
      // one selected axis is refused
      wr(2'd3, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd3, interp_pkg::REG_ENDPOINT, 32'h00000005);
      wr(2'd3, interp_pkg::REG_SPEED, 32'h00000004);
      wr(2'd3, interp_pkg::REG_COMMAND, 32'h00000801);
      repeat (3) @(posedge sys_clk);
      rd(2'd3, interp_pkg::REG_STATUS);
      `CHK(d[interp_pkg::STAT_ERR], 1'b1)
      `CHK(d[interp_pkg::STAT_RUN], 1'b0)
      `CHK(drv.pos[3], 0)
      // interval scaling table, equal endpoints so every fire is shared
      for (int k = 0; k < 5; k++) begin
         ctrl = 4;
         hi   = 0;
         for (int i = 3; i >= 0; i--) begin
            if (grp[k][i]) begin
               ctrl = i;
               hi   = (i > hi) ? i : hi;
               wr(2'(i), interp_pkg::REG_MODE, {16'h0000, flg[k][i], 8'h00, interp_pkg::MODE_LIN1});
               wr(2'(i), interp_pkg::REG_ENDPOINT, 32'h00000002);
            end
         end
         wr(2'(ctrl), interp_pkg::REG_SPEED, 32'h00000080);
         wr(2'(hi), interp_pkg::REG_COMMAND, {20'h00000, grp[k], interp_pkg::CMD_START});
         rd(2'(ctrl), interp_pkg::REG_INTERP_STATUS);
         `CHK(d[7:6], 2'(ctrl))
         wait_end(2'(ctrl));
         `CHK(drv.gap[ctrl], exp_gap[k])
      end
      // continuous linear 1 with zero endpoints
      p0 = drv.pos;
      wr(2'd0, interp_pkg::REG_MODE, 32'h00000060);
      wr(2'd1, interp_pkg::REG_MODE, 32'h00000060);
      wr(2'd0, interp_pkg::REG_ENDPOINT, 32'h00000000);
      wr(2'd1, interp_pkg::REG_ENDPOINT, 32'h00000000);
      wr(2'd0, interp_pkg::REG_SPEED, 32'h00000008);
      wr(2'd0, interp_pkg::REG_COMMAND, 32'h00000301);
      repeat (200) @(posedge sys_clk);
      rd(2'd0, interp_pkg::REG_STATUS);
      `CHK(d[interp_pkg::STAT_RUN], 1'b1)
      wr(2'd1, interp_pkg::REG_COMMAND, 32'h00000302);
      repeat (4) @(posedge sys_clk);
      rd(2'd1, interp_pkg::REG_STATUS);
      `CHK(d[1:0], 2'b10)
      `CHK(drv.pos[0] - p0[0], drv.pos[1] - p0[1])
      `CHK(drv.pos[0] - p0[0] > 10, 1'b1)
      // continuous linear 2, flags set but no scaling
      wr(2'd2, interp_pkg::REG_MODE, 32'h00008062);
      wr(2'd3, interp_pkg::REG_MODE, 32'h00008062);
      for (int i = 2; i < 4; i++) begin
         wr(2'(i), interp_pkg::REG_ENDPOINT, 32'h00000006);
         wr(2'(i), interp_pkg::REG_MASTER_AMOUNT, 32'h00000006);
         wr(2'(i), interp_pkg::REG_SPEED, 32'h0000000a);
      end
      wr(2'd3, interp_pkg::REG_COMMAND, 32'h00000c01);
      repeat (100) @(posedge sys_clk);
      `CHK(drv.gap[2], 10)
      `CHK(drv.gap[3], 10)
      rd(2'd3, interp_pkg::REG_SPEED_MON);
      `CHK(d, 32'h0000000a)
      wr(2'd2, interp_pkg::REG_COMMAND, 32'h00000c02);
      repeat (4) @(posedge sys_clk);
      rd(2'd3, interp_pkg::REG_STATUS);
      `CHK(d[1:0], 2'b10)
      // linear 2 with zero master amount is refused
      wr(2'd0, interp_pkg::REG_MODE, 32'h00000063);
      wr(2'd0, interp_pkg::REG_MASTER_AMOUNT, 32'h00000000);
      wr(2'd0, interp_pkg::REG_COMMAND, 32'h00000101);
      repeat (3) @(posedge sys_clk);
      rd(2'd0, interp_pkg::REG_STATUS);
      `CHK(d[interp_pkg::STAT_ERR], 1'b1)
      `CHK(d[interp_pkg::STAT_RUN], 1'b0)
      // circular x-z beside linear 1 y-u: two control axes
      wr(2'd0, interp_pkg::REG_MODE, 32'h00000064);
      wr(2'd2, interp_pkg::REG_MODE, 32'h00000064);
      wr(2'd1, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd3, interp_pkg::REG_MODE, 32'h00000061);
      wr(2'd3, interp_pkg::REG_COMMAND, 32'h00000f01);
      rd(2'd0, interp_pkg::REG_INTERP_STATUS);
      `CHK(d[11:0], 12'h97a)
      wait_end(2'd1);
      report_and_stop();
   end
endmodule
